// >>> core/aifs_pkg.sv
package aifs_pkg;
	// Register map
	localparam logic [7:0] REG_MOTION_FLAGS = 8'h09;
	localparam logic [7:0] REG_DATA_FLAGS   = 8'h0A;
	localparam logic [7:0] REG_KNOCK_SRC    = 8'h0B;
	localparam logic [7:0] REG_POSE_SRC     = 8'h0C;
	localparam logic [7:0] REG_QUEUE_FILL   = 8'h0E;
	localparam logic [7:0] REG_SCALE_SEL    = 8'h0F;
	localparam logic [7:0] REG_IRQ_STATUS   = 8'h20;
	localparam logic [7:0] REG_IRQ_CLEAR    = 8'h21;
	localparam logic [7:0] REG_IRQ_ENABLE   = 8'h22;

	// Bit positions in the motion flag register
	localparam int BIT_SLOPE  = 2;
	localparam int BIT_HIGH   = 1;
	localparam int BIT_D_TAP  = 4;
	localparam int BIT_S_TAP  = 5;

	// Scale select codes
	localparam logic [3:0] SCALE_2G    = 4'h3;
	localparam logic [3:0] SCALE_4G    = 4'h5;
	localparam logic [3:0] SCALE_8G    = 4'h8;
	localparam logic [3:0] SCALE_16G   = 4'hC;
	localparam logic [3:0] SCALE_RESET = SCALE_2G;

	// Latch mode codes
	localparam logic [3:0] LATCH_NONE   = 4'h0;
	localparam logic [3:0] LATCH_PERM_A = 4'h7;
	localparam logic [3:0] LATCH_PERM_B = 4'hF;

	// Temporary latch time
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TEMP_LATCH_NS   = 20000;
	localparam int TEMP_LATCH_CYC  = TEMP_LATCH_NS / CLK_PERIOD_NS;
	localparam int TIMER_W         = 11;

	// Frame queue
	localparam logic [6:0] QUEUE_DEPTH = 7'h20;
	localparam logic [6:0] QUEUE_EMPTY = 7'h00;

	// Interrupt status bits
	localparam int IRQ_W         = 4;
	localparam int IRQ_MOTION    = 0;
	localparam int IRQ_DATA      = 1;
	localparam int IRQ_OVERRUN   = 2;
	localparam int IRQ_POSE      = 3;

	localparam int MOTION_W = 8;
	localparam int DATA_W   = 3;
endpackage

// >>> core/aifs_flag_latch.sv
`timescale 1ns/1ps
module aifs_flag_latch
	import aifs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       trig,
	input  wire logic [3:0] mode,
	input  wire logic       latch_clr,
	output logic            flag
);
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic               next_flag;

	wire mode_none = (mode == LATCH_NONE);
	wire mode_perm = (mode == LATCH_PERM_A) || (mode == LATCH_PERM_B);
	wire mode_temp = !mode_none && !mode_perm;
	wire expired   = mode_temp && (timer == '0);

	// Event beats clear in every mode
	assign next_flag  = mode_none ? trig :
	                    trig      ? 1'b1 :
	                    latch_clr ? 1'b0 :
	                    expired   ? 1'b0 : flag;
	assign next_timer = trig ? TIMER_W'(TEMP_LATCH_CYC - 1) :
	                    (flag && timer != '0) ? timer - 1'b1 : timer;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag  <= 1'b0;
			timer <= '0;
		end else begin
			flag  <= next_flag;
			timer <= next_timer;
		end
	end

	a_flag_set: assert property (@(posedge clk) disable iff (rst)
		trig |=> flag) else $error("flag not set by its trigger");
	a_flag_follow: assert property (@(posedge clk) disable iff (rst)
		mode_none |=> flag == $past(trig)) else $error("unlatched flag not following");
	a_temp_expiry: assert property (@(posedge clk) disable iff (rst)
		flag && expired && !trig && !latch_clr |=> !flag)
		else $error("temporary latch did not expire");
endmodule // aifs_flag_latch

// >>> core/aifs_frame_counter.sv
`timescale 1ns/1ps
module aifs_frame_counter
	import aifs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic       cfg_wr,
	output logic [6:0]      count,
	output logic            overrun
);
	logic [6:0] next_count;
	logic       next_overrun;

	wire full      = (count == QUEUE_DEPTH);
	wire push_only = push && !pop;
	wire pop_only  = pop && !push;
	wire overflow  = push_only && full;

	// Full queue drops the oldest frame, so the level stays at depth
	assign next_count = cfg_wr                 ? QUEUE_EMPTY :
	                    (push_only && !full)   ? count + 7'h01 :
	                    (pop_only && count != QUEUE_EMPTY) ? count - 7'h01 : count;
	assign next_overrun = overflow ? 1'b1 : cfg_wr ? 1'b0 : overrun;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count   <= QUEUE_EMPTY;
			overrun <= 1'b0;
		end else begin
			count   <= next_count;
			overrun <= next_overrun;
		end
	end

	a_count_clear: assert property (@(posedge clk) disable iff (rst)
		cfg_wr |=> count == QUEUE_EMPTY) else $error("frame count not cleared");
	a_overrun_hold: assert property (@(posedge clk) disable iff (rst)
		overrun && !cfg_wr |=> overrun) else $error("overrun flag lost");
	a_overrun_set: assert property (@(posedge clk) disable iff (rst)
		push && !pop && count == QUEUE_DEPTH |=> overrun)
		else $error("overrun not flagged");
endmodule // aifs_frame_counter

// >>> core/aifs_top.sv
// What this block does
// - Status flag sets when its engine triggers
// - Latch mode picks permanent, temporary or none
// - Motion flags: flat down to low-g
// - Data ready, watermark, full on bits 7..5
// - Tap sign and z,y,x source on 7..4
// - Slope sign and z,y,x source on 3..0
// - High-g sign and z,y,x source bits
// - Flat bit valid only while flat enabled
// - Bit 6 gives z facing up or down
// - Bits 5..4 give x-y plane orientation
// - Orientation live while unblocked, ignoring latch mode
// - Orientation holds while blocking condition active
// - Overrun sticky until queue configuration write
// - Bits 6..0 give stored frame count
// - Count clears on drain or configuration write
// - Scale select codes, reset to 2g
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module aifs_top
(
	input  wire logic                        CLK,
	input  wire logic                        SYS_RST,
	input  wire logic [7:0]                  ADDR,
	input  wire logic [7:0]                  WDATA,
	input  wire logic                        WR,
	input  wire logic                        RD,
	output logic      [7:0]                  RDATA,
	input  wire logic [aifs_pkg::MOTION_W-1:0] MOTION_TRIG,
	input  wire logic [aifs_pkg::DATA_W-1:0]   DATA_FIFO_TRIG,
	input  wire logic [3:0]                  LATCH_MODE,
	input  wire logic                        LATCH_CLR,
	input  wire logic [3:0]                  TAP_SRC,
	input  wire logic [3:0]                  SLOPE_SRC,
	input  wire logic [3:0]                  HIGH_SRC,
	input  wire logic [2:0]                  ORIENT,
	input  wire logic                        ORIENT_BLOCK,
	input  wire logic                        FLAT_POS,
	input  wire logic                        FLAT_EN,
	input  wire logic                        FRAME_PUSH,
	input  wire logic                        FRAME_POP,
	input  wire logic                        FIFO_CFG_WR,
	output logic      [3:0]                  RANGE_SEL,
	output logic                             IRQ
);
	import aifs_pkg::*;

	// Flag array: motion flags in the low byte, data/queue flags above
	localparam int NFLAG = MOTION_W + DATA_W;

	logic [NFLAG-1:0]   flag_trig;
	logic [NFLAG-1:0]   flags;
	logic [3:0]         tap_src;
	logic [3:0]         slope_src;
	logic [3:0]         high_src;
	logic [2:0]         pose;
	logic               flat;
	logic [6:0]         frame_count;
	logic               overrun;
	logic               overrun_q;
	logic [IRQ_W-1:0]   irq_stat;
	logic [IRQ_W-1:0]   irq_en;
	logic [IRQ_W-1:0]   next_irq_stat;
	logic [IRQ_W-1:0]   next_irq_en;
	logic [IRQ_W-1:0]   irq_event;
	logic [IRQ_W-1:0]   clr_mask;
	logic [3:0]         next_range;
	logic [3:0]         next_tap_src;
	logic [3:0]         next_slope_src;
	logic [3:0]         next_high_src;
	logic [2:0]         next_pose;
	logic               next_flat;
	logic [7:0]         rd_mux;
	logic [7:0]         next_rdata;

	assign flag_trig = {DATA_FIFO_TRIG, MOTION_TRIG};

	// One latch per flag
	genvar gi;
	generate
		for (gi = 0; gi < NFLAG; gi++) begin : g_flag
			aifs_flag_latch u_latch (
				.clk       (CLK),
				.rst       (SYS_RST),
				.trig      (flag_trig[gi]),
				.mode      (LATCH_MODE),
				.latch_clr (LATCH_CLR),
				.flag      (flags[gi])
			);
		end
	endgenerate

	aifs_frame_counter u_fill (
		.clk     (CLK),
		.rst     (SYS_RST),
		.push    (FRAME_PUSH),
		.pop     (FRAME_POP),
		.cfg_wr  (FIFO_CFG_WR),
		.count   (frame_count),
		.overrun (overrun)
	);

	// Address decode
	wire hit_motion  = (ADDR == REG_MOTION_FLAGS);
	wire hit_data    = (ADDR == REG_DATA_FLAGS);
	wire hit_knock   = (ADDR == REG_KNOCK_SRC);
	wire hit_pose    = (ADDR == REG_POSE_SRC);
	wire hit_queue   = (ADDR == REG_QUEUE_FILL);
	wire hit_scale   = (ADDR == REG_SCALE_SEL);
	wire hit_istat   = (ADDR == REG_IRQ_STATUS);
	wire hit_iclr    = (ADDR == REG_IRQ_CLEAR);
	wire hit_ien     = (ADDR == REG_IRQ_ENABLE);

	wire wr_scale = WR && hit_scale;
	wire wr_clear = WR && hit_iclr;
	wire wr_en    = WR && hit_ien;

	// Source capture on the triggering engine
	wire tap_hit   = MOTION_TRIG[BIT_S_TAP] || MOTION_TRIG[BIT_D_TAP];
	wire slope_hit = MOTION_TRIG[BIT_SLOPE];
	wire high_hit  = MOTION_TRIG[BIT_HIGH];

	assign next_tap_src   = tap_hit   ? TAP_SRC   : tap_src;
	assign next_slope_src = slope_hit ? SLOPE_SRC : slope_src;
	assign next_high_src  = high_hit  ? HIGH_SRC  : high_src;
	// Orientation bypasses the latch and freezes while blocked
	assign next_pose      = ORIENT_BLOCK ? pose : ORIENT;
	assign next_flat      = FLAT_EN ? FLAT_POS : 1'b0;

	// Host writes only touch the scale and interrupt registers
	assign next_range = wr_scale ? WDATA[3:0] : RANGE_SEL;

	// Sticky interrupt status, set beats clear
	assign irq_event[IRQ_MOTION]  = |MOTION_TRIG;
	assign irq_event[IRQ_DATA]    = |DATA_FIFO_TRIG;
	assign irq_event[IRQ_OVERRUN] = overrun && !overrun_q;
	assign irq_event[IRQ_POSE]    = (next_pose != pose);
	assign clr_mask      = wr_clear ? WDATA[IRQ_W-1:0] : '0;
	assign next_irq_stat = (irq_stat & ~clr_mask) | irq_event;
	assign next_irq_en   = wr_en ? WDATA[IRQ_W-1:0] : irq_en;

	// Read selection; unmapped and write-only addresses read zero
	assign rd_mux =
		({8{hit_motion}} & flags[MOTION_W-1:0]) |
		({8{hit_data}}   & {flags[NFLAG-1:MOTION_W], 5'h00}) |
		({8{hit_knock}}  & {tap_src, slope_src}) |
		({8{hit_pose}}   & {flat, pose, high_src}) |
		({8{hit_queue}}  & {overrun, frame_count}) |
		({8{hit_scale}}  & {4'h0, RANGE_SEL}) |
		({8{hit_istat}}  & {4'h0, irq_stat}) |
		({8{hit_ien}}    & {4'h0, irq_en});
	assign next_rdata = RD ? rd_mux : 8'h00;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tap_src   <= 4'h0;
			slope_src <= 4'h0;
			high_src  <= 4'h0;
			pose      <= 3'h0;
			flat      <= 1'b0;
		end else begin
			tap_src   <= next_tap_src;
			slope_src <= next_slope_src;
			high_src  <= next_high_src;
			pose      <= next_pose;
			flat      <= next_flat;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RANGE_SEL <= SCALE_RESET;
			irq_stat  <= '0;
			irq_en    <= '0;
			overrun_q <= 1'b0;
			IRQ       <= 1'b0;
			RDATA     <= 8'h00;
		end else begin
			RANGE_SEL <= next_range;
			irq_stat  <= next_irq_stat;
			irq_en    <= next_irq_en;
			overrun_q <= overrun;
			IRQ       <= |(next_irq_stat & next_irq_en);
			RDATA     <= next_rdata;
		end
	end

	a_range_write: assert property (@(posedge CLK) disable iff (SYS_RST)
		WR && ADDR == REG_SCALE_SEL |=> RANGE_SEL == $past(WDATA[3:0]))
		else $error("scale select not written");
	a_range_read: assert property (@(posedge CLK) disable iff (SYS_RST)
		RD && ADDR == REG_SCALE_SEL |=> RDATA == {4'h0, $past(RANGE_SEL)})
		else $error("scale select read mismatch");
	a_ro_ignored: assert property (@(posedge CLK) disable iff (SYS_RST)
		WR && ADDR == REG_KNOCK_SRC && !tap_hit && !slope_hit
		|=> $stable(tap_src) && $stable(slope_src))
		else $error("read-only source changed by write");
	a_tap_capture: assert property (@(posedge CLK) disable iff (SYS_RST)
		tap_hit |=> tap_src == $past(TAP_SRC)) else $error("tap source not captured");
	a_high_capture: assert property (@(posedge CLK) disable iff (SYS_RST)
		high_hit ##1 !high_hit |=> high_src == $past(high_src))
		else $error("high-g source not held");
	a_pose_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
		ORIENT_BLOCK |=> $stable(pose)) else $error("orientation moved while blocked");
	a_pose_live: assert property (@(posedge CLK) disable iff (SYS_RST)
		!ORIENT_BLOCK |=> pose == $past(ORIENT)) else $error("orientation not live");
	a_flat_valid: assert property (@(posedge CLK) disable iff (SYS_RST)
		!FLAT_EN |=> !flat) else $error("flat shown while disabled");
	a_queue_read: assert property (@(posedge CLK) disable iff (SYS_RST)
		RD && ADDR == REG_QUEUE_FILL |=> RDATA[6:0] == $past(frame_count))
		else $error("frame count read mismatch");
	a_irq_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
		irq_event[IRQ_MOTION]
		|=> irq_stat[IRQ_MOTION] && (!irq_en[IRQ_MOTION] || IRQ))
		else $error("motion event lost");
endmodule // aifs_top

// >>> bench/aifs_host.sv
`timescale 1ns/1ps
module aifs_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	initial begin
		addr  = 8'h00;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
	end
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule // aifs_host

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
	import aifs_pkg::*;
	logic       clk, sys_rst, wr, rd, lclr, oblk, fpos, fen, push, pop, cfgwr, irq;
	logic [7:0] addr, wdata, rdata, mtrig, d, keep;
	logic [2:0] dtrig, orient;
	logic [3:0] lmode, tsrc, ssrc, hsrc, rsel;
	logic [31:0] seed, r;
	logic [3:0] codes [4];
	int         fails, total_checks, cyc;

	aifs_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	aifs_top dut (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .MOTION_TRIG(mtrig), .DATA_FIFO_TRIG(dtrig), .LATCH_MODE(lmode),
		.LATCH_CLR(lclr), .TAP_SRC(tsrc), .SLOPE_SRC(ssrc), .HIGH_SRC(hsrc), .ORIENT(orient),
		.ORIENT_BLOCK(oblk), .FLAT_POS(fpos), .FLAT_EN(fen), .FRAME_PUSH(push), .FRAME_POP(pop),
		.FIFO_CFG_WR(cfgwr), .RANGE_SEL(rsel), .IRQ(irq));

	always #5 clk = ~clk;

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Upper nibble of the pose register: flat bit masked by its enable
	function logic [3:0] pose_hi(logic fe, logic fp, logic [2:0] o);
		return {fe & fp, o};
	endfunction

	task test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task cycles(int n);
		repeat (n) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		{clk, lclr, oblk, fpos, fen, push, pop, cfgwr} = '0;
		{mtrig, dtrig, orient, lmode, tsrc, ssrc, hsrc} = '0;
		sys_rst = 1'b1;
		seed = 32'd71815;
		codes = '{SCALE_4G, SCALE_8G, SCALE_16G, SCALE_2G};
		cycles(3);
		sys_rst <= 1'b0;
		host.reg_rd(REG_SCALE_SEL, d);
		`CHK("scale reset", 8'h03, d)
		host.reg_rd(8'h30, d);
		`CHK("unmapped", 8'h00, d)
		for (int i = 0; i < 4; i++) begin
			host.reg_wr(REG_SCALE_SEL, {4'h0, codes[i]});
			host.reg_rd(REG_SCALE_SEL, d);
			`CHK("scale read", {4'h0, codes[i]}, d)
			`CHK("scale pin", codes[i], rsel)
		end
		// Unlatched flags follow random triggers
		fen <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			r = xs();
			@(posedge clk);
			mtrig <= r[7:0];
			dtrig <= r[10:8];
			host.reg_rd(REG_MOTION_FLAGS, d);
			`CHK("motion flags", mtrig, d)
			host.reg_rd(REG_DATA_FLAGS, d);
			`CHK("data flags", {dtrig, 5'h00}, d)
		end
		mtrig <= 8'h00;
		dtrig <= 3'h0;
		// Permanent latch with captured sources, both codes
		for (int j = 0; j < 2; j++) begin
			r = xs();
			@(posedge clk);
			lmode <= j ? LATCH_PERM_B : LATCH_PERM_A;
			mtrig <= 8'h26;
			{hsrc, ssrc, tsrc} <= r[11:0];
			@(posedge clk);
			mtrig <= 8'h00;
			{hsrc, ssrc, tsrc} <= ~r[11:0];
			cycles(5);
			host.reg_rd(REG_MOTION_FLAGS, d);
			`CHK("latched flags", 8'h26, d)
			host.reg_rd(REG_KNOCK_SRC, d);
			`CHK("tap slope src", {r[3:0], r[7:4]}, d)
			host.reg_wr(REG_KNOCK_SRC, ~d);
			host.reg_rd(REG_KNOCK_SRC, d);
			`CHK("knock ro", {r[3:0], r[7:4]}, d)
			host.reg_rd(REG_POSE_SRC, d);
			`CHK("high src", r[11:8], d[3:0])
			@(posedge clk);
			lclr <= 1'b1;
			@(posedge clk);
			lclr <= 1'b0;
			host.reg_rd(REG_MOTION_FLAGS, d);
			`CHK("cleared flags", 8'h00, d)
		end
		// Temporary latch expires
		@(posedge clk);
		lmode <= 4'h1;
		mtrig <= 8'h01;
		@(posedge clk);
		mtrig <= 8'h00;
		cycles(100);
		host.reg_rd(REG_MOTION_FLAGS, d);
		`CHK("temp held", 8'h01, d)
		cycles(2000);
		host.reg_rd(REG_MOTION_FLAGS, d);
		`CHK("temp expired", 8'h00, d)
		// Orientation stays live under a permanent latch
		lmode <= LATCH_PERM_B;
		for (logic [3:0] i = 0; i < 8; i++) begin
			@(posedge clk);
			orient <= i[2:0];
			fpos <= i[0];
			host.reg_rd(REG_POSE_SRC, d);
			`CHK("pose", pose_hi(1'b1, i[0], i[2:0]), d[7:4])
		end
		keep = d;
		@(posedge clk);
		oblk <= 1'b1;
		orient <= 3'h2;
		host.reg_rd(REG_POSE_SRC, d);
		`CHK("pose blocked", keep[6:4], d[6:4])
		fen <= 1'b0;
		host.reg_rd(REG_POSE_SRC, d);
		`CHK("flat disabled", 1'b0, d[7])
		// Frame count, overrun, interrupt masking and clear
		host.reg_wr(REG_IRQ_CLEAR, 8'h0F);
		host.reg_wr(REG_IRQ_ENABLE, 8'h00);
		for (int n = 0; n < 39; n++) begin
			// Queue is quiet while its level is read back
			if (n == 3 || n == 6) begin
				@(posedge clk);
				push <= 1'b0;
				pop <= 1'b0;
				host.reg_rd(REG_QUEUE_FILL, d);
				if (n == 3)
					`CHK("count three", 8'h03, d)
				else
					`CHK("drained", 8'h00, d)
			end
			@(posedge clk);
			push <= (n < 3 || n > 5);
			pop <= (n >= 3 && n <= 5);
		end
		@(posedge clk);
		push <= 1'b0;
		pop <= 1'b0;
		host.reg_rd(REG_QUEUE_FILL, d);
		`CHK("overrun full", 8'hA0, d)
		host.reg_rd(REG_IRQ_STATUS, d);
		`CHK("status overrun", 1'b1, d[IRQ_OVERRUN])
		`CHK("irq masked", 1'b0, irq)
		host.reg_wr(REG_QUEUE_FILL, 8'h00);
		host.reg_rd(REG_QUEUE_FILL, d);
		`CHK("ro write", 8'hA0, d)
		host.reg_wr(REG_IRQ_ENABLE, 8'h04);
		cycles(2);
		`CHK("irq set", 1'b1, irq)
		host.reg_wr(REG_IRQ_CLEAR, 8'h04);
		cycles(2);
		`CHK("irq cleared", 1'b0, irq)
		@(posedge clk);
		cfgwr <= 1'b1;
		@(posedge clk);
		cfgwr <= 1'b0;
		host.reg_rd(REG_QUEUE_FILL, d);
		`CHK("cfg clear", 8'h00, d)
		test_done();
	end
endmodule // tb_top
